// ### rtl/embc_defs.vh
// Operation
// R01 - Drive the program fetch strobe low during external code accesses.
// R02 - Keep the program fetch strobe high outside external code accesses.
// R03 - Latch the code space strap at reset release and ignore later changes.
// R04 - Strap latched low: every code fetch goes to the external bus.
// R05 - Strap latched high: fetch internally below the limit, externally above it.
// R06 - After reset the shared strap pin acts as the bus wait input.
// R07 - Wait held high stretches an external access until wait falls.
// R08 - Bus timing high register resets to FF with write/read time and hold fields.
// R09 - Bus timing low register resets to EF with multiplier, latch width, code fields.
// R10 - Latch the bus width strap at reset release: low 8-bit, high 16-bit.
// R11 - Pulse the address latch strobe only for external bus cycles.
// R12 - Sample wait on the core clock, one extra strobe clock per high sample.
`ifndef EMBC_DEFS_VH
`define EMBC_DEFS_VH
// Register indices; byte address is four times the index
`define EMBC_IDX_BTL 11'h468
`define EMBC_IDX_BTH 11'h469
`define EMBC_IDX_BCFG 11'h46A
`define EMBC_IDX_STAT 11'h46B
// Reset values
`define EMBC_RST_BTL 8'hEF
`define EMBC_RST_BTH 8'hFF
`define EMBC_RST_BCFG_LO 2'h3
// Bus timing high field positions
`define EMBC_BTH_WT 7:6
`define EMBC_BTH_WAH 5:4
`define EMBC_BTH_RT 3:2
`define EMBC_BTH_RAH 1:0
// Bus timing low field positions
`define EMBC_BTL_WM 7:6
`define EMBC_BTL_ALE_WIDE 5
`define EMBC_BTL_CRT 3:2
`define EMBC_BTL_CRAH 1:0
// Bus configuration field positions
`define EMBC_BCFG_WAIT_OFF 4
`define EMBC_BCFG_BUS_OFF 3
`define EMBC_BCFG_WIDTH 2
`define EMBC_BCFG_FLD 2:0
// Access kinds
`define EMBC_KIND_CODE 2'h0
`define EMBC_KIND_READ 2'h1
`define EMBC_KIND_WRITE 2'h2
// Timing counts in core clocks
`define EMBC_ALE_BASE 2'h0
`define EMBC_STRB_BASE 3'h1
`endif

// ### rtl/embc_sync.v
`timescale 1ns/1ns
module embc_sync #(
  parameter W = 1
) (
  // Clock
  input wire clock,
  // Raw pins and settled levels
  input wire [W-1:0] pin_in,
  output wire [W-1:0] level_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_ff;
      reg s2_ff;
      reg s3_ff;
      reg lvl_ff;
      // Three stages, no reset so straps are tracked during reset
      always @(posedge clock) begin
        s1_ff <= pin_in[i];
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        if (s2_ff == s3_ff) begin
          lvl_ff <= s3_ff; // Change counts once stages agree
        end
      end
      assign level_out[i] = lvl_ff;
    end
  endgenerate
endmodule // embc_sync

// ### rtl/embc_regs.v
`timescale 1ns/1ns
`include "embc_defs.vh"
module embc_regs #(
  parameter ADR_W = 13
) (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // Block state in, settings out
  input wire width_strap,
  input wire [7:0] status,
  output wire [7:0] bus_timing_low,
  output wire [7:0] bus_timing_high,
  output wire [7:0] bus_configuration
);
  reg ack_ff;
  reg [7:0] rdat_ff;
  reg [7:0] btl_ff;
  reg [7:0] bth_ff;
  reg [7:0] bcfg_ff;
  reg [7:0] nxt_rdat;
  wire [10:0] idx = wb_adr_i[ADR_W-1:2];
  wire take = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire wr_lane = take & wb_we_i & wb_sel_i[0];

  // Read mux, unmapped reads zero
  always @* begin
    nxt_rdat = 8'h00;
    case (idx)
      `EMBC_IDX_BTL: nxt_rdat = btl_ff;
      `EMBC_IDX_BTH: nxt_rdat = bth_ff;
      `EMBC_IDX_BCFG: nxt_rdat = bcfg_ff;
      `EMBC_IDX_STAT: nxt_rdat = status;
      default: nxt_rdat = 8'h00;
    endcase
  end

  // Ack and register writes
  always @(posedge clock) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
      rdat_ff <= 8'h00;
      btl_ff <= `EMBC_RST_BTL; // R09
      bth_ff <= `EMBC_RST_BTH; // R08
      bcfg_ff <= {5'h00, width_strap, `EMBC_RST_BCFG_LO}; // R10
    end else begin
      ack_ff <= take;
      if (take) begin
        rdat_ff <= nxt_rdat;
      end
      if (wr_lane && idx == `EMBC_IDX_BTL) begin
        btl_ff <= wb_dat_i[7:0];
      end
      if (wr_lane && idx == `EMBC_IDX_BTH) begin
        bth_ff <= wb_dat_i[7:0];
      end
      if (wr_lane && idx == `EMBC_IDX_BCFG) begin
        bcfg_ff <= {3'h0, wb_dat_i[4:0]};
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = {24'h000000, rdat_ff};
  assign bus_timing_low = btl_ff;
  assign bus_timing_high = bth_ff;
  assign bus_configuration = bcfg_ff;
endmodule // embc_regs

// ### rtl/embc_top.v
`timescale 1ns/1ns
`include "embc_defs.vh"
module embc_top #(
  parameter ADR_W = 13,
  parameter [23:0] INT_CODE_SIZE = 24'h004000
) (
  // Clock and reset
  input wire clock,
  input wire sys_rst,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // Core access port
  input wire acc_req,
  input wire [1:0] acc_kind,
  input wire [23:0] acc_addr,
  input wire [15:0] acc_wdata,
  output reg acc_done_ff,
  output reg int_fetch_ff,
  output reg [15:0] acc_rdata_ff,
  // Strap pins
  input wire code_space_select_strap,
  input wire bus_width_strap,
  // External bus pins
  output reg program_fetch_strobe_n_ff,
  output reg ale_ff,
  output reg rd_n_ff,
  output reg wrl_n_ff,
  output reg wrh_n_ff,
  output reg [23:0] bus_addr_ff,
  output reg [15:0] bus_dout_ff,
  output reg bus_doe_n_ff,
  input wire [15:0] bus_din,
  // Latched straps
  output reg code_sel_ff,
  output reg wide_bus_ff
);
  // Sequencer states
  localparam ST_IDLE = 3'h0;
  localparam ST_ALE = 3'h1;
  localparam ST_STRB = 3'h2;
  localparam ST_HOLD = 3'h3;
  localparam ST_DONE = 3'h4;

  wire [1:0] strap_lvl;
  wire wait_lvl;
  wire [7:0] btl;
  wire [7:0] bth;
  wire [7:0] bcfg;
  wire [7:0] status;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [2:0] cnt_ff;
  reg [2:0] nxt_cnt;
  reg [1:0] kind_ff;
  reg [1:0] nxt_kind;
  reg [15:0] wdata_ff;
  reg [15:0] nxt_wdata;
  reg [23:0] nxt_bus_addr;
  reg [15:0] nxt_rdata;
  reg nxt_done;
  reg nxt_int_fetch;
  reg nxt_ale;
  reg nxt_pfs_n;
  reg nxt_rd_n;
  reg nxt_wrl_n;
  reg nxt_wrh_n;
  reg nxt_doe_n;
  reg [15:0] nxt_dout;
  reg [1:0] strb_fld;
  reg [1:0] hold_fld;
  reg go_ext;

  // Strap and wait pin synchronisers
  embc_sync #(
    .W(2)
  ) u_sync (
    .clock(clock),
    .pin_in({bus_width_strap, code_space_select_strap}),
    .level_out(strap_lvl)
  );

  // Shared pin is wait once reset is gone
  assign wait_lvl = strap_lvl[0] & ~sys_rst & ~bcfg[`EMBC_BCFG_WAIT_OFF]; // R06

  assign status = {4'h0, wait_lvl, (state_ff != ST_IDLE), wide_bus_ff, code_sel_ff};

  // Register file on the bus
  embc_regs #(
    .ADR_W(ADR_W)
  ) u_regs (
    .clock(clock),
    .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .width_strap(strap_lvl[1]),
    .status(status),
    .bus_timing_low(btl),
    .bus_timing_high(bth),
    .bus_configuration(bcfg)
  );

  // Strap capture, frozen at reset release
  always @(posedge clock) begin
    if (sys_rst) begin
      code_sel_ff <= strap_lvl[0]; // R03
      wide_bus_ff <= strap_lvl[1]; // R10
    end
  end

  // Strobe and hold lengths per access kind
  always @* begin
    strb_fld = btl[`EMBC_BTL_CRT];
    hold_fld = btl[`EMBC_BTL_CRAH];
    case (kind_ff)
      `EMBC_KIND_CODE: begin
        strb_fld = btl[`EMBC_BTL_CRT];
        hold_fld = btl[`EMBC_BTL_CRAH];
      end
      `EMBC_KIND_READ: begin
        strb_fld = bth[`EMBC_BTH_RT];
        hold_fld = bth[`EMBC_BTH_RAH];
      end
      `EMBC_KIND_WRITE: begin
        strb_fld = bth[`EMBC_BTH_WT];
        hold_fld = bth[`EMBC_BTH_WAH];
      end
      default: begin
        strb_fld = bth[`EMBC_BTH_RT];
        hold_fld = bth[`EMBC_BTH_RAH];
      end
    endcase
  end

  // Internal or external decision for a new request
  always @* begin
    go_ext = 1'b1;
    if (acc_kind == `EMBC_KIND_CODE && code_sel_ff && acc_addr < INT_CODE_SIZE) begin
      go_ext = 1'b0; // R05
    end
    if (acc_kind == `EMBC_KIND_CODE && !code_sel_ff) begin
      go_ext = 1'b1; // R04
    end
  end

  // Bus sequencer next state
  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_kind = kind_ff;
    nxt_wdata = wdata_ff;
    nxt_bus_addr = bus_addr_ff;
    nxt_rdata = acc_rdata_ff;
    nxt_done = 1'b0;
    nxt_int_fetch = 1'b0;
    nxt_ale = 1'b0;
    nxt_pfs_n = 1'b1;
    nxt_rd_n = 1'b1;
    nxt_wrl_n = 1'b1;
    nxt_wrh_n = 1'b1;
    nxt_doe_n = 1'b1;
    nxt_dout = bus_dout_ff;
    case (state_ff)
      ST_IDLE: begin
        if (acc_req) begin
          if (go_ext) begin
            nxt_state = ST_ALE;
            nxt_kind = acc_kind;
            nxt_wdata = acc_wdata;
            nxt_bus_addr = acc_addr;
            nxt_ale = 1'b1; // R11
            nxt_cnt = btl[`EMBC_BTL_ALE_WIDE] ? 3'h1 : {1'b0, `EMBC_ALE_BASE};
          end else begin
            nxt_state = ST_DONE;
            nxt_int_fetch = 1'b1;
            nxt_done = 1'b1;
          end
        end
      end
      ST_ALE: begin
        if (cnt_ff != 3'h0) begin
          nxt_cnt = cnt_ff - 3'h1;
          nxt_ale = 1'b1; // R11
        end else begin
          nxt_state = ST_STRB;
          nxt_cnt = {1'b0, strb_fld} + `EMBC_STRB_BASE - 3'h1;
          nxt_pfs_n = (kind_ff != `EMBC_KIND_CODE); // R01 R02
          nxt_rd_n = (kind_ff != `EMBC_KIND_READ);
          nxt_wrl_n = (kind_ff != `EMBC_KIND_WRITE);
          nxt_wrh_n = (kind_ff != `EMBC_KIND_WRITE) | ~bcfg[`EMBC_BCFG_WIDTH];
          nxt_doe_n = (kind_ff != `EMBC_KIND_WRITE);
          nxt_dout = wdata_ff;
        end
      end
      ST_STRB: begin
        if (wait_lvl || cnt_ff != 3'h0) begin
          // Each high wait sample adds one strobe clock
          if (!wait_lvl) begin
            nxt_cnt = cnt_ff - 3'h1;
          end
          nxt_pfs_n = program_fetch_strobe_n_ff; // R07 R12
          nxt_rd_n = rd_n_ff;
          nxt_wrl_n = wrl_n_ff;
          nxt_wrh_n = wrh_n_ff;
          nxt_doe_n = bus_doe_n_ff;
        end else begin
          // Read data taken as the strobe ends
          if (bcfg[`EMBC_BCFG_WIDTH]) begin
            nxt_rdata = bus_din;
          end else begin
            nxt_rdata = {8'h00, bus_din[7:0]};
          end
          nxt_doe_n = bus_doe_n_ff;
          if (hold_fld == 2'h0) begin
            nxt_state = ST_DONE;
            nxt_done = 1'b1;
            nxt_doe_n = 1'b1;
          end else begin
            nxt_state = ST_HOLD;
            nxt_cnt = {1'b0, hold_fld} - 3'h1;
          end
        end
      end
      ST_HOLD: begin
        if (cnt_ff != 3'h0) begin
          nxt_cnt = cnt_ff - 3'h1;
          nxt_doe_n = bus_doe_n_ff;
        end else begin
          nxt_state = ST_DONE;
          nxt_done = 1'b1;
        end
      end
      ST_DONE: begin
        // One idle clock so a held request is not taken twice
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Sequencer and pin registers
  always @(posedge clock) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 3'h0;
      kind_ff <= `EMBC_KIND_CODE;
      wdata_ff <= 16'h0000;
      acc_done_ff <= 1'b0;
      int_fetch_ff <= 1'b0;
      acc_rdata_ff <= 16'h0000;
      program_fetch_strobe_n_ff <= 1'b1; // R02
      ale_ff <= 1'b0;
      rd_n_ff <= 1'b1;
      wrl_n_ff <= 1'b1;
      wrh_n_ff <= 1'b1;
      bus_addr_ff <= 24'h000000;
      bus_dout_ff <= 16'h0000;
      bus_doe_n_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      kind_ff <= nxt_kind;
      wdata_ff <= nxt_wdata;
      acc_done_ff <= nxt_done;
      int_fetch_ff <= nxt_int_fetch;
      acc_rdata_ff <= nxt_rdata;
      program_fetch_strobe_n_ff <= nxt_pfs_n;
      ale_ff <= nxt_ale;
      rd_n_ff <= nxt_rd_n;
      wrl_n_ff <= nxt_wrl_n;
      wrh_n_ff <= nxt_wrh_n;
      bus_addr_ff <= nxt_bus_addr;
      bus_dout_ff <= nxt_dout;
      bus_doe_n_ff <= nxt_doe_n;
    end
  end
endmodule // embc_top

// ### dv/embc_top_assertions.sv
`timescale 1ns/1ns
module embc_top_assertions #(
  parameter [23:0] INT_CODE_SIZE = 24'h004000
) (
  // Clock, reset and bus handshake
  input wire clock,
  input wire sys_rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  // Core port
  input wire acc_req,
  input wire [1:0] acc_kind,
  input wire [23:0] acc_addr,
  input wire acc_done_ff,
  input wire int_fetch_ff,
  // Pins and latched straps
  input wire program_fetch_strobe_n_ff,
  input wire ale_ff,
  input wire rd_n_ff,
  input wire wrl_n_ff,
  input wire wrh_n_ff,
  input wire code_sel_ff,
  input wire wide_bus_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_fetch_code;
    !program_fetch_strobe_n_ff |-> acc_req && acc_kind == 2'h0 && rd_n_ff && wrl_n_ff;
  endproperty
  a_fetch_code: assert property (p_fetch_code) else $error("fetch strobe outside code fetch");
  property p_ext_zero;
    $rose(acc_req) && acc_kind == 2'h0 && !code_sel_ff |-> ##[1:40] !program_fetch_strobe_n_ff;
  endproperty
  a_ext_zero: assert property (p_ext_zero) else $error("no external fetch strobe");
  property p_no_int;
    int_fetch_ff |-> code_sel_ff && acc_done_ff;
  endproperty
  a_no_int: assert property (p_no_int) else $error("internal fetch with strap low");
  property p_int_fast;
    $rose(acc_req) && acc_kind == 2'h0 && code_sel_ff && acc_addr < INT_CODE_SIZE
      |=> int_fetch_ff && acc_done_ff;
  endproperty
  a_int_fast: assert property (p_int_fast) else $error("internal fetch not served");
  property p_straps;
    !$past(sys_rst) |-> $stable(code_sel_ff) && $stable(wide_bus_ff);
  endproperty
  a_straps: assert property (p_straps) else $error("strap changed after release");
  property p_ale_ext;
    $rose(ale_ff) |-> $past(acc_req) && !int_fetch_ff;
  endproperty
  a_ale_ext: assert property (p_ale_ext) else $error("latch strobe without bus cycle");
  property p_strobe_min;
    $fell(rd_n_ff) |-> !rd_n_ff [*4];
  endproperty
  a_strobe_min: assert property (p_strobe_min) else $error("read strobe too short");
  property p_wide;
    !wrh_n_ff |-> wide_bus_ff;
  endproperty
  a_wide: assert property (p_wide) else $error("high write on narrow bus");
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("register ack not one pulse");
endmodule // embc_top_assertions
bind embc_top embc_top_assertions #(.INT_CODE_SIZE(INT_CODE_SIZE)) embc_top_assertions_inst (
  .clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .acc_req(acc_req), .acc_kind(acc_kind), .acc_addr(acc_addr),
  .acc_done_ff(acc_done_ff), .int_fetch_ff(int_fetch_ff),
  .program_fetch_strobe_n_ff(program_fetch_strobe_n_ff), .ale_ff(ale_ff),
  .rd_n_ff(rd_n_ff), .wrl_n_ff(wrl_n_ff), .wrh_n_ff(wrh_n_ff),
  .code_sel_ff(code_sel_ff), .wide_bus_ff(wide_bus_ff));

// ### dv/embc_mem_model.sv
`timescale 1ns/1ns
module embc_mem_model (
  // Strobes, address and write data
  input wire program_fetch_strobe_n,
  input wire rd_n,
  input wire wrl_n,
  input wire [23:0] addr,
  input wire [15:0] wdata,
  // Read data and last write
  output reg [15:0] rdata = 16'h0000,
  output reg [15:0] wr_seen = 16'h0000
);
  // Addressed data while selected, inverse of last value when released
  always @(program_fetch_strobe_n or rd_n or addr) begin
    if (!program_fetch_strobe_n || !rd_n) rdata = addr[15:0] ^ 16'hA55A;
    else rdata = ~rdata;
  end
  // Store write data at the end of the strobe
  always @(posedge wrl_n) wr_seen = wdata;
endmodule // embc_mem_model

// ### dv/test_external_memory_bus_control.sv
`timescale 1ns/1ns
module test_external_memory_bus_control;
  reg clock = 1'b0;
  reg sys_rst = 1'b1;
  reg cyc = 1'b0, stb = 1'b0, we = 1'b0, req = 1'b0, strap = 1'b1, wide = 1'b0;
  reg [12:0] adr = 13'h0000;
  reg [3:0] sel = 4'h0;
  reg [31:0] wdat = 32'h00000000, rv;
  reg [1:0] kind = 2'h0;
  reg [23:0] addr = 24'h000000;
  reg [15:0] awd = 16'h0000, rd;
  reg fi;
  wire [31:0] rdat;
  wire [15:0] ard, din, dout, wseen;
  wire [23:0] badr;
  wire ack, done, intf, pfs_n, ale, rd_n, wrl_n, wrh_n, doe_n, csel, wsel;
  integer errors = 0, checks = 0, n, np, nr, na, nd;
  always #5 clock = ~clock;
  embc_top embc_top_inst (.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .acc_req(req), .acc_kind(kind), .acc_addr(addr), .acc_wdata(awd),
    .acc_done_ff(done), .int_fetch_ff(intf), .acc_rdata_ff(ard),
    .code_space_select_strap(strap), .bus_width_strap(wide),
    .program_fetch_strobe_n_ff(pfs_n), .ale_ff(ale), .rd_n_ff(rd_n), .wrl_n_ff(wrl_n),
    .wrh_n_ff(wrh_n), .bus_addr_ff(badr), .bus_dout_ff(dout), .bus_doe_n_ff(doe_n),
    .bus_din(din), .code_sel_ff(csel), .wide_bus_ff(wsel));
  embc_mem_model embc_mem_model_inst (.program_fetch_strobe_n(pfs_n), .rd_n(rd_n),
    .wrl_n(wrl_n), .addr(badr), .wdata(dout), .rdata(din), .wr_seen(wseen));
  // Compare and count
  task chk(input string what, input [31:0] exp, input [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Single classic register cycle
  task wb(input w, input [12:0] a, input [31:0] d);
    @(posedge clock);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      test_done;
    end
    rv = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    sel <= 4'h0;
  endtask
  // One core access, counting strobe cycles
  task acc(input [1:0] k, input [23:0] a);
    @(posedge clock);
    req <= 1'b1; kind <= k; addr <= a; awd <= a[15:0] ^ 16'h3C3C;
    n = 0; np = 0; nr = 0; na = 0; nd = 0;
    do begin
      @(posedge clock);
      n++;
      np += (pfs_n === 1'b0);
      nr += (rd_n === 1'b0);
      na += (ale === 1'b1);
      nd += (doe_n === 1'b0);
    end while (done !== 1'b1 && n < 200);
    if (n >= 200) begin
      errors++;
      test_done;
    end
    fi = intf; rd = ard;
    req <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0; strap <= 1'b0;
    @(posedge clock);
    chk("code_sel", 1, csel);
    chk("wide_bus", 0, wsel);
    wb(0, 13'h11A0, 0); chk("bus_timing_low", 32'h000000EF, rv);
    wb(0, 13'h11A4, 0); chk("bus_timing_high", 32'h000000FF, rv);
    wb(0, 13'h11A8, 0); chk("bus_configuration", 32'h00000003, rv);
    wb(0, 13'h1FFC, 0); chk("unmapped", 0, rv);
    wb(0, 13'h11AC, 0); chk("status", 32'h00000001, rv);
    wb(1, 13'h11A4, 32'h0000005A); wb(0, 13'h11A4, 0); chk("bth write", 32'h5A, rv);
    wb(1, 13'h11A4, 32'h000000FF);
    $display("test registers done");
    acc(0, 24'h000100); chk("int fetch", 1, fi); chk("int strobe", 0, np);
    chk("int latch", 0, na);
    acc(0, 24'h008000); chk("ext fetch", 0, fi); chk("ext strobe", 4, np);
    chk("ext latch", 2, na);
    chk("fetch data", 8'h5A, rd[7:0]);
    acc(1, 24'h000123); chk("read strobe", 4, nr); chk("fetch strobe on read", 0, np);
    chk("read drive", 0, nd);
    chk("read data", 8'h79, rd[7:0]);
    acc(2, 24'h000456); chk("write data", 8'h6A, wseen[7:0]); chk("fetch strobe on write", 0, np);
    chk("write drive", 7, nd);
    $display("test accesses done");
    @(posedge clock) strap <= 1'b1;
    fork
      acc(1, 24'h000200);
      begin
        repeat (12) @(posedge clock);
        strap <= 1'b0;
      end
    join
    chk("stretch", 1, nr > 4);
    chk("code_sel kept", 1, csel);
    $display("test wait done");
    sys_rst <= 1'b1; strap <= 1'b0; wide <= 1'b1;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk("code_sel low", 0, csel);
    chk("wide_bus high", 1, wsel);
    wb(0, 13'h11A8, 0); chk("bus_configuration wide", 32'h00000007, rv);
    wb(0, 13'h11AC, 0); chk("status wide", 32'h00000002, rv);
    acc(0, 24'h000100); chk("forced ext", 0, fi); chk("forced strobe", 4, np);
    chk("wide data", 16'hA45A, rd);
    acc(2, 24'h000300); chk("wide write", 16'h3F3C, wseen);
    chk("wide drive", 7, nd);
    $display("test external strap done");
    test_done;
  end
endmodule // test_external_memory_bus_control
